// ==== design/pcsr_regs.v ====
// Indexed control and status register set of the 10/100 PHY
`include "pcsr_defines.vh"

module pcsr_regs #(
  parameter [15:0] OUI_BITS_3_18  = 16'h1234, // Arbitrary value
  parameter [5:0]  OUI_BITS_19_24 = 6'h2a,    // Arbitrary value
  parameter [5:0]  MODEL_NUMBER   = 6'h05,    // Arbitrary value
  parameter [3:0]  REVISION       = 4'h1,     // Arbitrary value
  parameter [2:0]  MODE_RST       = 3'h7
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // Indexed access from the MAC management logic
  input  wire [4:0]  index_in,
  input  wire        wr_en_in,
  input  wire [15:0] wr_data_in,
  input  wire        rd_en_in,
  output reg  [15:0] rd_data_out,
  output reg         rd_valid_out,
  // Straps and live conditions
  input  wire        speed_strap_in,
  input  wire        link_up_in,
  input  wire        jabber_in,
  input  wire        remote_fault_in,
  input  wire        an_complete_in,
  input  wire        an_speed_100_in,
  input  wire        an_full_duplex_in,
  input  wire        energy_on_in,
  input  wire [15:0] partner_ability_in,
  input  wire [15:0] expansion_in,
  input  wire [15:0] int_source_in,
  // Controls to the PHY
  output reg         soft_reset_out,
  output reg         loopback_out,
  output reg         an_enable_out,
  output reg         an_restart_out,
  output reg         power_down_out,
  output reg         col_test_out,
  output reg         speed_100_out,
  output reg         full_duplex_out,
  output reg         edpd_enable_out,
  output reg  [2:0]  phy_mode_out,
  output reg  [4:0]  phy_addr_out,
  output reg  [15:0] int_mask_out,
  output reg  [15:0] advert_out,
  output reg         pause_sym_out,
  output reg         pause_asym_out
);

  // ***************************************
  // State
  // ***************************************
  reg        strap_done;
  reg        strap_speed;
  reg        ctl_loopback;
  reg        ctl_speed;
  reg        ctl_an_en;
  reg        ctl_pwr_down;
  reg        ctl_duplex;
  reg        ctl_col_test;
  reg        adv_rfault;
  reg        adv_resv12;
  reg  [1:0] adv_pause;
  reg  [3:0] adv_ability;
  reg  [4:0] adv_selector;
  reg        mode_edpd;
  reg  [7:0] kept_over_soft_reset;
  reg  [15:0] indicate_reg;
  reg  [15:0] spec_ctl_reg;
  reg  [15:0] int_mask_reg;
  reg        lat_link_low;
  reg        lat_jabber;
  reg        lat_rfault;

  wire       wr_ctl;
  wire       soft_rst_req;
  wire       rd_status;
  wire [15:0] ctl_word;
  wire [15:0] status_word;
  wire [15:0] adv_word;
  wire [15:0] mode_word;
  reg  [15:0] next_rd_data;

  // Accesses on the strap capture edge are dropped so defaults land cleanly
  function wr_hit;
    input [4:0] idx;
    begin
      wr_hit = wr_en_in && strap_done && (index_in == idx);
    end
  endfunction

  assign wr_ctl       = wr_hit(`PCSR_IDX_CONTROL);
  assign soft_rst_req = wr_ctl && wr_data_in[`PCSR_CTL_RESET];
  assign rd_status    = rd_en_in && strap_done && (index_in == `PCSR_IDX_STATUS);

  // ***************************************
  // Strap capture after reset release
  // ***************************************
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_done  <= 1'b0;
      strap_speed <= 1'b0;
    end else if (!strap_done) begin
      strap_done  <= 1'b1;
      strap_speed <= speed_strap_in;
    end
  end

  // ***************************************
  // Control register
  // ***************************************
  // Reset in the write wins over the other bits of that write
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_loopback <= 1'b0;
      ctl_speed    <= 1'b0;
      ctl_an_en    <= 1'b0;
      ctl_pwr_down <= 1'b0;
      ctl_duplex   <= 1'b0;
      ctl_col_test <= 1'b0;
    end else if (!strap_done || soft_rst_req) begin
      ctl_loopback <= 1'b0;
      ctl_speed    <= (!strap_done) ? speed_strap_in : strap_speed;
      ctl_an_en    <= (!strap_done) ? speed_strap_in : strap_speed;
      ctl_pwr_down <= 1'b0;
      ctl_duplex   <= 1'b0;
      ctl_col_test <= 1'b0;
    end else if (wr_ctl) begin
      ctl_loopback <= wr_data_in[`PCSR_CTL_LOOPBACK];
      ctl_speed    <= wr_data_in[`PCSR_CTL_SPEED];
      ctl_an_en    <= wr_data_in[`PCSR_CTL_AN_EN];
      ctl_pwr_down <= wr_data_in[`PCSR_CTL_PWR_DOWN];
      ctl_duplex   <= wr_data_in[`PCSR_CTL_DUPLEX];
      ctl_col_test <= wr_data_in[`PCSR_CTL_COL_TEST];
    end
  end

  // Self-clearing bits always read zero; reserved bits read zero
  assign ctl_word = {1'b0, ctl_loopback, ctl_speed, ctl_an_en, ctl_pwr_down, 1'b0, 1'b0,
                     ctl_duplex, ctl_col_test, 7'h00};

  // ***************************************
  // Advertisement register
  // ***************************************
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      adv_rfault   <= 1'b0;
      adv_resv12   <= 1'b0;
      adv_pause    <= `PCSR_ADV_PAUSE_RST;
      adv_ability  <= 4'h2;
      adv_selector <= `PCSR_SELECTOR_RST;
    end else if (!strap_done || soft_rst_req) begin
      adv_rfault   <= 1'b0;
      adv_resv12   <= 1'b0;
      adv_pause    <= `PCSR_ADV_PAUSE_RST;
      adv_ability  <= (!strap_done) ? {speed_strap_in, 1'b1, 2'b11} :
                                      {strap_speed, 1'b1, 2'b11};
      adv_selector <= `PCSR_SELECTOR_RST;
    end else if (wr_hit(`PCSR_IDX_ADVERT)) begin
      adv_rfault   <= wr_data_in[13];
      adv_resv12   <= wr_data_in[12];
      adv_pause    <= wr_data_in[11:10];
      adv_ability  <= wr_data_in[8:5];
      adv_selector <= wr_data_in[4:0];
    end
  end

  assign adv_word = {2'b00, adv_rfault, adv_resv12, adv_pause, 1'b0, adv_ability,
                     adv_selector};

  // ***************************************
  // Mode, special modes and vendor registers
  // ***************************************
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_edpd    <= 1'b0;
      indicate_reg <= 16'h0000;
      spec_ctl_reg <= 16'h0000;
      int_mask_reg <= 16'h0000;
    end else if (soft_rst_req) begin
      mode_edpd    <= 1'b0;
      indicate_reg <= 16'h0000;
      spec_ctl_reg <= 16'h0000;
      int_mask_reg <= 16'h0000;
    end else begin
      if (wr_hit(`PCSR_IDX_MODE_CTL)) begin
        mode_edpd <= wr_data_in[`PCSR_MODE_EDPD];
      end
      if (wr_hit(`PCSR_IDX_INDICATE)) begin
        indicate_reg <= wr_data_in;
      end
      if (wr_hit(`PCSR_IDX_SPEC_CTL)) begin
        spec_ctl_reg <= wr_data_in;
      end
      if (wr_hit(`PCSR_IDX_INT_MASK)) begin
        int_mask_reg <= wr_data_in;
      end
    end
  end

  assign mode_word = {2'b00, mode_edpd, 11'h000, energy_on_in, 1'b0};

  // Only the hardware reset touches these; a soft reset leaves them alone
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kept_over_soft_reset <= {MODE_RST, `PCSR_PHYAD_RST};
    end else if (wr_hit(`PCSR_IDX_SPECIAL) && !soft_rst_req) begin
      kept_over_soft_reset <= wr_data_in[7:0];
    end
  end

  // ***************************************
  // Latched status
  // ***************************************
  // A new event in the read cycle wins over the clear
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lat_link_low <= 1'b0;
      lat_jabber   <= 1'b0;
      lat_rfault   <= 1'b0;
    end else begin
      if (!link_up_in) begin
        lat_link_low <= 1'b1;
      end else if (rd_status || soft_rst_req) begin
        lat_link_low <= 1'b0;
      end
      if (jabber_in) begin
        lat_jabber <= 1'b1;
      end else if (rd_status || soft_rst_req) begin
        lat_jabber <= 1'b0;
      end
      if (remote_fault_in) begin
        lat_rfault <= 1'b1;
      end else if (rd_status || soft_rst_req) begin
        lat_rfault <= 1'b0;
      end
    end
  end

  assign status_word = `PCSR_STATUS_FIXED
                     | {10'h000, an_complete_in & ~ctl_pwr_down,
                        remote_fault_in | lat_rfault,
                        1'b0,
                        link_up_in & ~lat_link_low,
                        jabber_in | lat_jabber,
                        1'b0};

  // ***************************************
  // Read decode
  // ***************************************
  always @* begin
    next_rd_data = 16'h0000;
    if (index_in == `PCSR_IDX_CONTROL) begin
      next_rd_data = ctl_word;
    end else if (index_in == `PCSR_IDX_STATUS) begin
      next_rd_data = status_word;
    end else if (index_in == `PCSR_IDX_ID_HIGH) begin
      next_rd_data = OUI_BITS_3_18;
    end else if (index_in == `PCSR_IDX_ID_LOW) begin
      next_rd_data = {OUI_BITS_19_24, MODEL_NUMBER, REVISION};
    end else if (index_in == `PCSR_IDX_ADVERT) begin
      next_rd_data = adv_word;
    end else if (index_in == `PCSR_IDX_PARTNER) begin
      next_rd_data = partner_ability_in;
    end else if (index_in == `PCSR_IDX_EXPANSION) begin
      next_rd_data = expansion_in;
    end else if (index_in == `PCSR_IDX_MODE_CTL) begin
      next_rd_data = mode_word;
    end else if (index_in == `PCSR_IDX_SPECIAL) begin
      next_rd_data = {8'h00, kept_over_soft_reset};
    end else if (index_in == `PCSR_IDX_INDICATE) begin
      next_rd_data = indicate_reg;
    end else if (index_in == `PCSR_IDX_INT_SRC) begin
      next_rd_data = int_source_in;
    end else if (index_in == `PCSR_IDX_INT_MASK) begin
      next_rd_data = int_mask_reg;
    end else if (index_in == `PCSR_IDX_SPEC_CTL) begin
      next_rd_data = spec_ctl_reg;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in && strap_done;
      if (rd_en_in && strap_done) begin
        rd_data_out <= next_rd_data;
      end
    end
  end

  // ***************************************
  // Control outputs
  // ***************************************
  // Both pause kinds advertised still resolve to one kind at most
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_reset_out  <= 1'b0;
      loopback_out    <= 1'b0;
      an_enable_out   <= 1'b0;
      an_restart_out  <= 1'b0;
      power_down_out  <= 1'b0;
      col_test_out    <= 1'b0;
      speed_100_out   <= 1'b0;
      full_duplex_out <= 1'b0;
      edpd_enable_out <= 1'b0;
      phy_mode_out    <= 3'h0;
      phy_addr_out    <= 5'h00;
      int_mask_out    <= 16'h0000;
      advert_out      <= 16'h0000;
      pause_sym_out   <= 1'b0;
      pause_asym_out  <= 1'b0;
    end else begin
      soft_reset_out  <= soft_rst_req;
      an_restart_out  <= wr_ctl && !soft_rst_req && wr_data_in[`PCSR_CTL_AN_RESTART];
      loopback_out    <= ctl_loopback;
      an_enable_out   <= ctl_an_en;
      power_down_out  <= ctl_pwr_down;
      col_test_out    <= ctl_col_test;
      speed_100_out   <= ctl_an_en ? an_speed_100_in : ctl_speed;
      full_duplex_out <= ctl_an_en ? an_full_duplex_in : ctl_duplex;
      edpd_enable_out <= mode_edpd;
      phy_mode_out    <= kept_over_soft_reset[7:5];
      phy_addr_out    <= kept_over_soft_reset[4:0];
      int_mask_out    <= int_mask_reg;
      advert_out      <= adv_word;
      pause_sym_out   <= an_complete_in && adv_pause[0] && partner_ability_in[10];
      pause_asym_out  <= an_complete_in && adv_pause[1] && partner_ability_in[11]
                         && !(adv_pause[0] && partner_ability_in[10]);
    end
  end

endmodule

// ==== design/pcsr_defines.vh ====
// Register indexes, field positions, reset values and fixed codes of the PHY register set
`ifndef PCSR_DEFINES_VH
`define PCSR_DEFINES_VH

// ***************************************
// Register indexes
// ***************************************
`define PCSR_IDX_CONTROL    5'h00
`define PCSR_IDX_STATUS     5'h01
`define PCSR_IDX_ID_HIGH    5'h02
`define PCSR_IDX_ID_LOW     5'h03
`define PCSR_IDX_ADVERT     5'h04
`define PCSR_IDX_PARTNER    5'h05
`define PCSR_IDX_EXPANSION  5'h06
`define PCSR_IDX_MODE_CTL   5'h11
`define PCSR_IDX_SPECIAL    5'h12
`define PCSR_IDX_INDICATE   5'h1b
`define PCSR_IDX_INT_SRC    5'h1d
`define PCSR_IDX_INT_MASK   5'h1e
`define PCSR_IDX_SPEC_CTL   5'h1f

// ***************************************
// Field positions
// ***************************************
`define PCSR_CTL_RESET      15
`define PCSR_CTL_LOOPBACK   14
`define PCSR_CTL_SPEED      13
`define PCSR_CTL_AN_EN      12
`define PCSR_CTL_PWR_DOWN   11
`define PCSR_CTL_AN_RESTART 9
`define PCSR_CTL_DUPLEX     8
`define PCSR_CTL_COL_TEST   7
`define PCSR_MODE_EDPD      13
`define PCSR_MODE_ENERGY    1

// ***************************************
// Fixed values and reset values
// ***************************************
`define PCSR_STATUS_FIXED   16'h7809
`define PCSR_SELECTOR_RST   5'h01
`define PCSR_PHYAD_RST      5'h01
`define PCSR_ADV_PAUSE_RST  2'h0

`endif

// ==== verif/pcsr_checker.sv ====
// Port assertions for the PHY register set
module pcsr_checker #(
  parameter [15:0] OUI_BITS_3_18 = 16'h1234
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Indexed access
  input wire logic [4:0]  index_in,
  input wire logic        wr_en_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  // Controls
  input wire logic        soft_reset_out,
  input wire logic        an_restart_out,
  input wire logic [15:0] advert_out,
  input wire logic        pause_sym_out,
  input wire logic        pause_asym_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Requests at the first edge after reset are dropped, so checks wait
  logic up;
  wire  rd  = rd_en_in & up;
  wire  wr0 = wr_en_in & up & (index_in == 5'h00);
  wire  hit = (index_in <= 5'h06) | (index_in == 5'h11) | (index_in == 5'h12) | (index_in == 5'h1b)
              | (index_in >= 5'h1d);
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      up <= 1'b0;
    else
      up <= 1'b1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_read_answer: assert property (rd |=> rd_valid_out) else $error("read not answered");
  a_valid_cause: assert property (rd_valid_out |-> $past(rd_en_in)) else $error("stray read valid");
  a_unmapped_zero: assert property (rd && !hit |=> rd_data_out == 16'h0000) else $error("unmapped data");
  a_soft_pulse: assert property (wr0 && wr_data_in[15] |=> soft_reset_out) else $error("no soft reset");
  a_soft_cause: assert property ($rose(soft_reset_out) |-> $past(wr_en_in && index_in == 5'h00 && wr_data_in[15]))
    else $error("stray soft reset");
  a_restart_pulse: assert property (wr0 && wr_data_in[9] && !wr_data_in[15] |=> an_restart_out)
    else $error("no restart pulse");
  a_restart_cause: assert property (an_restart_out |-> $past(wr_en_in && index_in == 5'h00 && wr_data_in[9]))
    else $error("stray restart");
  a_ctl_reserved: assert property (rd && index_in == 5'h00 |=> (rd_data_out & 16'h867f) == 16'h0000)
    else $error("control reserved bits");
  a_status_fixed: assert property (rd && index_in == 5'h01 |=> (rd_data_out & 16'hf809) == 16'h7809)
    else $error("status fixed bits");
  a_id_high: assert property (rd && index_in == 5'h02 |=> rd_data_out == OUI_BITS_3_18)
    else $error("identifier high");
  a_adv_reserved: assert property ((advert_out & 16'hc200) == 16'h0000) else $error("advert reserved");
  a_pause_single: assert property (!(pause_sym_out && pause_asym_out)) else $error("both pause");
endmodule

// ==== verif/pcsr_mac_model.sv ====
// MAC-side model issuing indexed register accesses
module pcsr_mac_model (
  // Clock and answer
  input  wire logic        clk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  // Indexed request
  output logic [4:0]  idx_out,
  output logic        wr_en_out,
  output logic [15:0] wr_data_out,
  output logic        rd_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    idx_out = 5'h00;
    wr_en_out = 1'b0;
    wr_data_out = 16'h0000;
    rd_en_out = 1'b0;
  end
  // Idle lines invert so a stale value never passes
  task automatic write_reg(input logic [4:0] i, input logic [15:0] d);
    @(negedge clk_in);
    idx_out = i;
    wr_data_out = d;
    wr_en_out = 1'b1;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    idx_out = ~i;
    wr_data_out = ~d;
  endtask
  task automatic read_reg(input logic [4:0] i, output logic [15:0] d, output logic ok);
    @(negedge clk_in);
    idx_out = i;
    rd_en_out = 1'b1;
    @(negedge clk_in);
    rd_en_out = 1'b0;
    idx_out = ~i;
    repeat (4) if (rd_valid_in !== 1'b1) @(negedge clk_in);
    ok = rd_valid_in === 1'b1;
    d = rd_data_in;
  endtask
endmodule

// ==== verif/phy_control_status_regs_tb_top.sv ====
// Self-checking bench for the PHY register set
module phy_control_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  localparam logic [15:0] OUI   = 16'h5a3c; // Arbitrary value
  localparam logic [5:0]  OUI_B = 6'h15;    // Arbitrary value
  localparam logic [5:0]  MODEL = 6'h0b;    // Arbitrary value
  localparam logic [3:0]  REV   = 4'h3;     // Arbitrary value
  logic        clk_in = 1'b0, rst_b_in = 1'b0, speed_strap_in = 1'b1, link_up_in = 1'b0, jabber_in = 1'b0;
  logic        remote_fault_in = 1'b0, an_complete_in = 1'b0, an_speed_100_in = 1'b0;
  logic        an_full_duplex_in = 1'b0, energy_on_in = 1'b0;
  logic [15:0] partner_ability_in = 16'h0000, expansion_in = 16'h0000, int_source_in = 16'h0000;
  logic [4:0]  index_in, phy_addr_out;
  logic        wr_en_in, rd_en_in, rd_valid_out, soft_reset_out, loopback_out, an_enable_out, an_restart_out;
  logic        power_down_out, col_test_out, speed_100_out, full_duplex_out, edpd_enable_out;
  logic        pause_sym_out, pause_asym_out, m13, lj, lr, ll;
  logic [2:0]  phy_mode_out;
  logic [15:0] wr_data_in, rd_data_out, int_mask_out, advert_out, m_ctl, m_adv, m27, m30, m31, exp_stat, d;
  logic [15:0] m18 = 16'h00e1;
  int          num_errors = 0;
  int          checks = 0;
  pcsr_regs #(.OUI_BITS_3_18(OUI), .OUI_BITS_19_24(OUI_B), .MODEL_NUMBER(MODEL), .REVISION(REV)) dut (
    .clk_in, .rst_b_in, .index_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out, .rd_valid_out,
    .speed_strap_in, .link_up_in, .jabber_in, .remote_fault_in, .an_complete_in, .an_speed_100_in,
    .an_full_duplex_in, .energy_on_in, .partner_ability_in, .expansion_in, .int_source_in, .soft_reset_out,
    .loopback_out, .an_enable_out, .an_restart_out, .power_down_out, .col_test_out, .speed_100_out,
    .full_duplex_out, .edpd_enable_out, .phy_mode_out, .phy_addr_out, .int_mask_out, .advert_out,
    .pause_sym_out, .pause_asym_out);
  pcsr_mac_model mac (.clk_in, .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out), .idx_out(index_in),
    .wr_en_out(wr_en_in), .wr_data_out(wr_data_in), .rd_en_out(rd_en_in));
  always #20 clk_in = ~clk_in;
  // ****************
  // Reference model
  // ****************
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {lj, lr, ll} <= 3'b000;
    end else if (wr_en_in && index_in == 5'h00 && wr_data_in[15]) begin
      // An event still present at the soft reset edge wins over the clear
      {lj, lr, ll} <= {jabber_in, remote_fault_in, ~link_up_in};
    end else if (rd_en_in && index_in == 5'h01) begin
      exp_stat <= 16'h7809 | {10'h000, an_complete_in & ~m_ctl[11], remote_fault_in | lr, 1'b0,
                              link_up_in & ~ll, jabber_in | lj, 1'b0};
      {lj, lr, ll} <= {jabber_in, remote_fault_in, ~link_up_in};
    end else begin
      {lj, lr, ll} <= {lj | jabber_in, lr | remote_fault_in, ll | ~link_up_in};
    end
  end
  function automatic logic [15:0] exp_rd(input logic [4:0] i);
    case (i)
      5'h00: exp_rd = m_ctl;
      5'h01: exp_rd = exp_stat;
      5'h02: exp_rd = OUI;
      5'h03: exp_rd = {OUI_B, MODEL, REV};
      5'h04: exp_rd = m_adv;
      5'h05: exp_rd = partner_ability_in;
      5'h06: exp_rd = expansion_in;
      5'h11: exp_rd = {2'b00, m13, 11'h000, energy_on_in, 1'b0};
      5'h12: exp_rd = m18;
      5'h1b: exp_rd = m27;
      5'h1d: exp_rd = int_source_in;
      5'h1e: exp_rd = m30;
      5'h1f: exp_rd = m31;
      default: exp_rd = 16'h0000;
    endcase
  endfunction
  task automatic defaults;
    m_ctl = speed_strap_in ? 16'h3000 : 16'h0000;
    m_adv = speed_strap_in ? 16'h01e1 : 16'h00e1;
    m13 = 1'b0;
    m27 = 16'h0000;
    m30 = 16'h0000;
    m31 = 16'h0000;
  endtask
  task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, input logic g);
    chk_w(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] v);
    mac.write_reg(i, v);
    case (i)
      5'h00: if (v[15]) defaults(); else m_ctl = v & 16'h7980;
      5'h04: m_adv = v & 16'h3dff;
      5'h11: m13 = v[13];
      5'h12: m18 = v;
      5'h1b: m27 = v;
      5'h1e: m30 = v;
      5'h1f: m31 = v;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [4:0] i);
    logic [15:0] v;
    logic        ok;
    mac.read_reg(i, v, ok);
    chk_b("rd_valid", 1'b1, ok);
    chk_w("rd_data", exp_rd(i), v);
  endtask
  task automatic outs;
    repeat (2) @(negedge clk_in);
    chk_b("loopback", m_ctl[14], loopback_out);
    chk_b("an_enable", m_ctl[12], an_enable_out);
    chk_b("power_down", m_ctl[11], power_down_out);
    chk_b("col_test", m_ctl[7], col_test_out);
    chk_b("speed", m_ctl[12] ? an_speed_100_in : m_ctl[13], speed_100_out);
    chk_b("duplex", m_ctl[12] ? an_full_duplex_in : m_ctl[8], full_duplex_out);
    chk_w("advert", m_adv, advert_out);
    chk_w("mode_addr", {8'h00, m18[7:0]}, {8'h00, phy_mode_out, phy_addr_out});
  endtask
  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    void'($urandom(32'hc586));
    repeat (4) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    defaults();
    rd(5'h00);
    rd(5'h04);
    outs();
    {an_speed_100_in, an_full_duplex_in, energy_on_in, an_complete_in} = 4'($urandom);
    partner_ability_in = 16'($urandom);
    expansion_in = 16'($urandom);
    int_source_in = 16'($urandom);
    // Every index, read-only ones included, written then read back
    repeat (2) for (int i = 0; i < 32; i++) begin
      d = 16'($urandom);
      if (i == 0) d[15] = 1'b0;
      if (i == 17) d = d & 16'h2000;
      if (i == 18) d = d & 16'h00ff;
      wr(5'(i), d);
      rd(5'(i));
      if (i == 0 || i == 4) outs();
    end
    chk_w("int_mask", m30, int_mask_out);
    chk_b("edpd", m13, edpd_enable_out);
    an_complete_in = 1'b1;
    for (int k = 0; k < 16; k++) begin
      partner_ability_in[11:10] = 2'(k);
      wr(5'h04, 16'h01e1 | {4'h0, 2'(k >> 2), 10'h000});
      repeat (2) @(negedge clk_in);
      chk_b("pause_sym", k[2] & k[0], pause_sym_out);
      chk_b("pause_asym", ~(k[2] & k[0]) & k[3] & k[1], pause_asym_out);
    end
    wr(5'h00, 16'h0800);
    link_up_in = 1'b1;
    rd(5'h01);
    wr(5'h00, 16'h1200);
    rd(5'h00);
    rd(5'h01);
    jabber_in = 1'b1;
    @(negedge clk_in);
    jabber_in = 1'b0;
    remote_fault_in = 1'b1;
    @(negedge clk_in);
    remote_fault_in = 1'b0;
    link_up_in = 1'b0;
    @(negedge clk_in);
    link_up_in = 1'b1;
    rd(5'h01);
    rd(5'h01);
    wr(5'h00, 16'h4180);
    wr(5'h04, 16'h2c00);
    wr(5'h1e, 16'($urandom));
    wr(5'h12, 16'h005a);
    wr(5'h00, 16'h8000);
    rd(5'h00);
    rd(5'h04);
    rd(5'h12);
    outs();
    chk_w("int_mask", m30, int_mask_out);
    // Hard reset in mid-run with the other strap level
    rst_b_in = 1'b0;
    speed_strap_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    defaults();
    m18 = 16'h00e1;
    rd(5'h00);
    rd(5'h04);
    outs();
    final_report();
  end
  initial begin
    #800000;
    num_errors++;
    final_report();
  end
endmodule
bind pcsr_regs pcsr_checker #(.OUI_BITS_3_18(OUI_BITS_3_18)) chk (.clk_in, .rst_b_in, .index_in, .wr_en_in,
  .wr_data_in, .rd_en_in, .rd_data_out, .rd_valid_out, .soft_reset_out, .an_restart_out, .advert_out,
  .pause_sym_out, .pause_asym_out);
